//--- pkg/pvc_defines.vh
// register addresses, field positions and reset values of the vendor bank
// assumes a 5-bit register address as carried by the serial management frame
`ifndef PVC_DEFINES_VH
`define PVC_DEFINES_VH
`define PVC_ADDR_CTRL     5'h10
`define PVC_ADDR_STAT     5'h11
`define PVC_ADDR_MASK     5'h12
`define PVC_ADDR_INTERRUPT_STATUS_REG    5'h13
`define PVC_CTRL_LO_SPD   9
`define PVC_CTRL_HI_SPD   8
`define PVC_CTRL_NEG_STOP 7
`define PVC_CTRL_NS_CLR   6
`define PVC_CTRL_SLC_FRZ  5
`define PVC_CTRL_SLEEP    4
`define PVC_CTRL_RSV3     3
`define PVC_CTRL_SPEED    2
`define PVC_CTRL_POWER    1
`define PVC_CTRL_RSV0     0
`define PVC_CTRL_RESET    16'h0001
`define PVC_CTRL_WMASK    16'h03F7
`define PVC_STAT_LINK     10
`define PVC_STAT_LEDBYP   9
`define PVC_STAT_RXPWR    6
`define PVC_STAT_RXSPD    5
`define PVC_STAT_RXVER    4
`define PVC_MASK_RESET    16'h0000
`define PVC_MASK_WMASK    16'hFF0F
`define PVC_MDIO_PRE      32
`endif

//--- hw/pvc_mdio_slave.v
// serial management slave: clause-22 style frames on mdc/mdio
// assumes mdc already synchronous to clk_i; pin drive as two signals, data and enable
`timescale 1ns/1ps
`include "pvc_defines.vh"
module pvc_mdio_slave #(
  parameter [4:0] PHY_ADDR = 5'h01
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire        mdc_i,
  input  wire        mdio_i,
  output reg         mdio_o,
  output reg         mdio_oe_o,
  output reg         wr_o,
  output reg         rd_o,
  output reg  [4:0]  addr_o,
  output reg  [15:0] wdata_o,
  input  wire [15:0] rdata_i
);
  localparam S_IDLE = 4'b0001;
  localparam S_HEAD = 4'b0010;
  localparam S_TURN = 4'b0100;
  localparam S_DATA = 4'b1000;
  reg [3:0]  state_ff;
  reg        mdc_d_ff;
  reg [5:0]  cnt_ff;
  reg [13:0] hdr_ff;
  reg [15:0] sh_ff;
  wire rise = mdc_i & ~mdc_d_ff;
  wire fall = ~mdc_i & mdc_d_ff;
  wire is_rd = (hdr_ff[11:10] == 2'b10);
  wire mine  = (hdr_ff[9:5] == PHY_ADDR);
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff  <= S_IDLE;
      mdc_d_ff  <= 1'b0;
      cnt_ff    <= 6'h00;
      hdr_ff    <= 14'h0000;
      sh_ff     <= 16'h0000;
      mdio_o    <= 1'b1;
      mdio_oe_o <= 1'b0;
      wr_o      <= 1'b0;
      rd_o      <= 1'b0;
      addr_o    <= 5'h00;
      wdata_o   <= 16'h0000;
    end else if (ce_i) begin
      mdc_d_ff <= mdc_i;
      wr_o     <= 1'b0;
      rd_o     <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          // hold the read drive until the fall that closes the last data bit
          if (fall) mdio_oe_o <= 1'b0;
          if (rise) begin
            if (mdio_i) begin
              if (cnt_ff != 6'h3F) cnt_ff <= cnt_ff + 6'h01;
            end else begin
              // frame starts on the first zero after a full preamble
              if (cnt_ff >= 6'd`PVC_MDIO_PRE) begin
                state_ff <= S_HEAD;
                hdr_ff   <= 14'h0000;
              end
              cnt_ff <= 6'h00;
            end
          end
        end
        S_HEAD: if (rise) begin
          hdr_ff <= {hdr_ff[12:0], mdio_i};
          cnt_ff <= cnt_ff + 6'h01;
          if (cnt_ff == 6'd12) begin
            state_ff <= S_TURN;
            cnt_ff   <= 6'h00;
            addr_o   <= {hdr_ff[3:0], mdio_i};
          end
        end
        S_TURN: begin
          if (rise) cnt_ff <= cnt_ff + 6'h01;
          if (rise && cnt_ff == 6'h00 && is_rd && mine) begin
            rd_o  <= 1'b1;
            sh_ff <= rdata_i;
          end
          // drive the zero turnaround bit, then data, on falling edges
          if (fall && cnt_ff == 6'h01 && is_rd && mine) begin
            mdio_oe_o <= 1'b1;
            mdio_o    <= 1'b0;
          end
          if (rise && cnt_ff == 6'h01) begin
            state_ff <= S_DATA;
            cnt_ff   <= 6'h00;
          end
        end
        S_DATA: begin
          if (fall && is_rd && mine) begin
            mdio_o <= sh_ff[15];
            sh_ff  <= {sh_ff[14:0], 1'b0};
          end
          if (rise) begin
            if (!is_rd) sh_ff <= {sh_ff[14:0], mdio_i};
            cnt_ff <= cnt_ff + 6'h01;
            if (cnt_ff == 6'd15) begin
              state_ff <= S_IDLE;
              cnt_ff   <= 6'h00;
              if (!is_rd && mine) begin
                wr_o    <= 1'b1;
                wdata_o <= {sh_ff[14:0], mdio_i};
              end
            end
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule // pvc_mdio_slave

//--- hw/pvc_led_stretch.v
// pulse stretcher for one indicator output
// assumes one-cycle activity pulses from the datapath
`timescale 1ns/1ps
module pvc_led_stretch #(
  parameter W   = 16,
  parameter LEN = 16'hFFFF
) (
  input  wire clk_i,
  input  wire rst_i,
  input  wire ce_i,
  input  wire bypass_i,
  input  wire act_i,
  output reg  led_o
);
  reg [W-1:0] cnt_ff;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= {W{1'b0}};
      led_o  <= 1'b0;
    end else if (ce_i) begin
      if (bypass_i) begin
        cnt_ff <= {W{1'b0}};
        led_o  <= act_i;
      end else begin
        if (act_i) cnt_ff <= LEN[W-1:0];
        else if (cnt_ff != {W{1'b0}}) cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
        led_o <= act_i | (cnt_ff != {W{1'b0}});
      end
    end
  end
endmodule // pvc_led_stretch

//--- hw/pvc_vendor_regs.v
// vendor control, link status and interrupt mask bank with interrupt pin
// assumes straps, status inputs and event pulses are synchronous to clk_i
//
// Overview of operation
// - control bit 9 at one forces low transmit speed and sends remote commands
// - control bit 8 at one forces high transmit speed and sends remote commands
// - control bit 7 at one halts node address negotiation
// - writing one to control bit 6 clears the noise event register
// - control bit 5 at one freezes receive slice adaptation
// - control bit 4 at one enters sleep, oscillator and clock stay up
// - leaving sleep keeps configuration and resets the state machine
// - control bit 2 selects speed and loads from the speed strap at reset
// - control bit 1 selects power and loads from the power strap at reset
// - status bit 10 shows link integrity, zero after reset
// - status bit 9 at one bypasses led pulse stretching
// - status bit 6 shows received signal power high
// - status bit 5 shows high receive speed
// - status bit 4 shows received version not zero
// - reserved status bits written zero, read zero, reset zero
// - mask bits 15 to 10 block six software interrupt sources
// - mask bit 9 blocks received management word valid
// - mask bit 8 blocks transmit management word ready
// - mask bits 3 and 2 block frame received and frame sent
// - mask bits 1 and 0 block remote command in and out
// - status flags record events whatever the mask holds
`timescale 1ns/1ps
`include "pvc_defines.vh"
module pvc_vendor_regs #(
  parameter [4:0] PHY_ADDR = 5'h01,
  parameter       LED_W    = 16,
  parameter       LED_LEN  = 16'hFFFF
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire        mdc_i,
  input  wire        mdio_i,
  output wire        mdio_o,
  output wire        mdio_oe_o,
  input  wire        speed_strap_pin_i,
  input  wire        power_strap_pin_i,
  input  wire        link_up_flag_i,
  input  wire        rx_power_level_i,
  input  wire        rx_speed_level_i,
  input  wire        rx_version_nonzero_i,
  input  wire [5:0]  sw_irq_set_i,
  input  wire        rx_mgmt_word_valid_set_i,
  input  wire        tx_mgmt_word_ready_set_i,
  input  wire        frame_received_i,
  input  wire        frame_sent_i,
  input  wire        remote_cmd_in_i,
  input  wire        remote_cmd_out_i,
  input  wire        rx_act_i,
  input  wire        tx_act_i,
  output reg         remote_low_speed_cmd_o,
  output reg         remote_high_speed_cmd_o,
  output reg         node_addr_negotiation_stop_o,
  output reg         noise_event_clear_o,
  output reg         slice_adapt_freeze_o,
  output reg         sleep_request_o,
  output reg         fsm_reset_o,
  output reg         speed_high_o,
  output reg         power_high_o,
  output wire        led_rx_o,
  output wire        led_tx_o,
  output reg         irq_n_o
);
  reg  [15:0] ctrl_ff;
  reg  [15:0] nxt_ctrl;
  reg  [15:0] mask_ff;
  reg  [15:0] interrupt_status_reg_ff;
  reg  [15:0] nxt_interrupt_status_reg;
  reg         ledbyp_ff;
  reg  [3:0]  stat_ff;
  reg         strap_done_ff;
  reg  [15:0] rdata;
  wire        wr;
  wire [4:0]  addr;
  wire [15:0] wdata;
  wire [15:0] ev;

  function hit;
    input [4:0] a;
    input [4:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  pvc_mdio_slave #(
    .PHY_ADDR (PHY_ADDR)
  ) u_mdio (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .mdc_i     (mdc_i),
    .mdio_i    (mdio_i),
    .mdio_o    (mdio_o),
    .mdio_oe_o (mdio_oe_o),
    .wr_o      (wr),
    .rd_o      (),
    .addr_o    (addr),
    .wdata_o   (wdata),
    .rdata_i   (rdata)
  );

  // event vector laid out like the mask so one or-reduce serves all
  assign ev = {sw_irq_set_i, rx_mgmt_word_valid_set_i, tx_mgmt_word_ready_set_i, 4'h0,
               frame_received_i, frame_sent_i, remote_cmd_in_i, remote_cmd_out_i};

  always @* begin
    rdata = 16'h0000;
    if (hit(addr, `PVC_ADDR_CTRL)) rdata = ctrl_ff;
    else if (hit(addr, `PVC_ADDR_STAT)) begin
      rdata[`PVC_STAT_LINK]   = stat_ff[3];
      rdata[`PVC_STAT_LEDBYP] = ledbyp_ff;
      rdata[`PVC_STAT_RXPWR]  = stat_ff[2];
      rdata[`PVC_STAT_RXSPD]  = stat_ff[1];
      rdata[`PVC_STAT_RXVER]  = stat_ff[0];
    end
    else if (hit(addr, `PVC_ADDR_MASK)) rdata = mask_ff;
    else if (hit(addr, `PVC_ADDR_INTERRUPT_STATUS_REG)) rdata = interrupt_status_reg_ff;
  end

  always @* begin
    nxt_ctrl = ctrl_ff;
    if (wr && hit(addr, `PVC_ADDR_CTRL)) begin
      // reserved bits keep their fixed values whatever the host writes
      nxt_ctrl = (wdata & `PVC_CTRL_WMASK) | `PVC_CTRL_RESET;
    end
    // strap levels are caught once, on the first enabled cycle after release
    if (!strap_done_ff) begin
      nxt_ctrl[`PVC_CTRL_SPEED] = speed_strap_pin_i;
      nxt_ctrl[`PVC_CTRL_POWER] = power_strap_pin_i;
    end
  end

  always @* begin
    // set wins over a same-cycle clear
    nxt_interrupt_status_reg = interrupt_status_reg_ff;
    if (wr && hit(addr, `PVC_ADDR_INTERRUPT_STATUS_REG)) nxt_interrupt_status_reg = interrupt_status_reg_ff & ~wdata;
    nxt_interrupt_status_reg = nxt_interrupt_status_reg | (ev & `PVC_MASK_WMASK);
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff       <= `PVC_CTRL_RESET;
      mask_ff       <= `PVC_MASK_RESET;
      interrupt_status_reg_ff      <= 16'h0000;
      ledbyp_ff     <= 1'b0;
      stat_ff       <= 4'h0;
      strap_done_ff <= 1'b0;
    end else if (ce_i) begin
      strap_done_ff <= 1'b1;
      ctrl_ff       <= nxt_ctrl;
      interrupt_status_reg_ff      <= nxt_interrupt_status_reg;
      stat_ff       <= {link_up_flag_i, rx_power_level_i, rx_speed_level_i,
                        rx_version_nonzero_i};
      if (wr && hit(addr, `PVC_ADDR_STAT)) ledbyp_ff <= wdata[`PVC_STAT_LEDBYP];
      if (wr && hit(addr, `PVC_ADDR_MASK)) mask_ff <= wdata & `PVC_MASK_WMASK;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      remote_low_speed_cmd_o       <= 1'b0;
      remote_high_speed_cmd_o      <= 1'b0;
      node_addr_negotiation_stop_o <= 1'b0;
      noise_event_clear_o          <= 1'b0;
      slice_adapt_freeze_o         <= 1'b0;
      sleep_request_o              <= 1'b0;
      fsm_reset_o                  <= 1'b0;
      speed_high_o                 <= 1'b0;
      power_high_o                 <= 1'b0;
      irq_n_o                      <= 1'b1;
    end else if (ce_i) begin
      remote_low_speed_cmd_o       <= nxt_ctrl[`PVC_CTRL_LO_SPD];
      remote_high_speed_cmd_o      <= nxt_ctrl[`PVC_CTRL_HI_SPD];
      node_addr_negotiation_stop_o <= nxt_ctrl[`PVC_CTRL_NEG_STOP];
      // one pulse per write of one, so the noise register clears once
      noise_event_clear_o <= wr && hit(addr, `PVC_ADDR_CTRL) && wdata[`PVC_CTRL_NS_CLR];
      slice_adapt_freeze_o <= nxt_ctrl[`PVC_CTRL_SLC_FRZ];
      sleep_request_o      <= nxt_ctrl[`PVC_CTRL_SLEEP];
      // configuration stays in ctrl_ff; only the datapath machine is reset
      fsm_reset_o  <= ctrl_ff[`PVC_CTRL_SLEEP] & ~nxt_ctrl[`PVC_CTRL_SLEEP];
      speed_high_o <= nxt_ctrl[`PVC_CTRL_SPEED];
      power_high_o <= nxt_ctrl[`PVC_CTRL_POWER];
      irq_n_o      <= ~|(nxt_interrupt_status_reg & ~mask_ff);
    end
  end

  pvc_led_stretch #(
    .W   (LED_W),
    .LEN (LED_LEN)
  ) u_led_rx (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .bypass_i (ledbyp_ff),
    .act_i    (rx_act_i),
    .led_o    (led_rx_o)
  );

  pvc_led_stretch #(
    .W   (LED_W),
    .LEN (LED_LEN)
  ) u_led_tx (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .bypass_i (ledbyp_ff),
    .act_i    (tx_act_i),
    .led_o    (led_tx_o)
  );
endmodule // pvc_vendor_regs

//--- verif/pvc_vendor_regs_checker.sv
// port-level checker for the vendor bank
// assumes one clock domain, bound onto every pvc_vendor_regs instance
`timescale 1ns/1ps
module pvc_vendor_regs_checker (
  input wire       clk_i,
  input wire       rst_i,
  input wire       mdc_i,
  input wire       speed_strap_pin_i,
  input wire       power_strap_pin_i,
  input wire [5:0] sw_irq_set_i,
  input wire       rx_mgmt_word_valid_set_i,
  input wire       tx_mgmt_word_ready_set_i,
  input wire       frame_received_i,
  input wire       frame_sent_i,
  input wire       remote_cmd_in_i,
  input wire       remote_cmd_out_i,
  input wire       remote_low_speed_cmd_o,
  input wire       remote_high_speed_cmd_o,
  input wire       node_addr_negotiation_stop_o,
  input wire       noise_event_clear_o,
  input wire       slice_adapt_freeze_o,
  input wire       sleep_request_o,
  input wire       fsm_reset_o,
  input wire       speed_high_o,
  input wire       power_high_o,
  input wire       mdio_oe_o,
  input wire       irq_n_o
);
  wire ev_any = |{sw_irq_set_i, rx_mgmt_word_valid_set_i, tx_mgmt_word_ready_set_i,
                  frame_received_i, frame_sent_i, remote_cmd_in_i, remote_cmd_out_i};
  wire [4:0] ctl = {remote_low_speed_cmd_o, remote_high_speed_cmd_o,
                    node_addr_negotiation_stop_o, slice_adapt_freeze_o, sleep_request_o};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rst;
    $fell(rst_i) |-> irq_n_o && !mdio_oe_o && !sleep_request_o && !fsm_reset_o;
  endproperty
  a_rst: assert property (p_rst) else $error("bad value at reset release");
  // control levels move only in the wake of a write frame, mdc still high
  property p_ctrl;
    $changed(ctl) |-> mdc_i;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control moved outside a write");
  property p_ns;
    noise_event_clear_o |-> mdc_i ##1 !noise_event_clear_o;
  endproperty
  a_ns: assert property (p_ns) else $error("noise clear pulse wrong");
  property p_fsm;
    $fell(sleep_request_o) |-> ##[0:1] fsm_reset_o;
  endproperty
  a_fsm: assert property (p_fsm) else $error("no state reset on wake");
  property p_fsm_slp;
    fsm_reset_o |-> !sleep_request_o ##1 !fsm_reset_o;
  endproperty
  a_fsm_slp: assert property (p_fsm_slp) else $error("stray state reset");
  property p_strap;
    $fell(rst_i) |-> ##[1:2] (speed_high_o == speed_strap_pin_i &&
                              power_high_o == power_strap_pin_i);
  endproperty
  a_strap: assert property (p_strap) else $error("straps not loaded");
  property p_irq_set;
    $fell(irq_n_o) |-> mdc_i || $past(ev_any) || $past(ev_any, 2) || $past(ev_any, 3);
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq without cause");
  property p_irq_clr;
    $rose(irq_n_o) |-> mdc_i;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq released unasked");
endmodule // pvc_vendor_regs_checker
bind pvc_vendor_regs pvc_vendor_regs_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .mdc_i(mdc_i), .speed_strap_pin_i(speed_strap_pin_i),
  .power_strap_pin_i(power_strap_pin_i), .sw_irq_set_i(sw_irq_set_i),
  .rx_mgmt_word_valid_set_i(rx_mgmt_word_valid_set_i),
  .tx_mgmt_word_ready_set_i(tx_mgmt_word_ready_set_i), .frame_received_i(frame_received_i),
  .frame_sent_i(frame_sent_i), .remote_cmd_in_i(remote_cmd_in_i),
  .remote_cmd_out_i(remote_cmd_out_i), .remote_low_speed_cmd_o(remote_low_speed_cmd_o),
  .remote_high_speed_cmd_o(remote_high_speed_cmd_o),
  .node_addr_negotiation_stop_o(node_addr_negotiation_stop_o),
  .noise_event_clear_o(noise_event_clear_o), .slice_adapt_freeze_o(slice_adapt_freeze_o),
  .sleep_request_o(sleep_request_o), .fsm_reset_o(fsm_reset_o),
  .speed_high_o(speed_high_o), .power_high_o(power_high_o), .mdio_oe_o(mdio_oe_o),
  .irq_n_o(irq_n_o));

//--- verif/pvc_mdio_host.sv
// host management entity: makes mdc and the host half of mdio
// assumes the device drive pair is fed back; idle line sits at the pull-up
`timescale 1ns/1ps
module pvc_mdio_host (
  input  wire  clk_i,
  input  wire  dev_d_i,
  input  wire  dev_oe_i,
  output logic mdc_o,
  output wire  mdio_o
);
  logic d_ff = 1'b1;
  logic oe_ff = 1'b0;
  initial mdc_o = 1'b0;
  assign mdio_o = dev_oe_i ? dev_d_i : (oe_ff ? d_ff : 1'b1);
  // 4 clk per half period, 8 clk per mdc bit
  task automatic bit_t(input logic b, output logic s);
    d_ff <= b;
    mdc_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    mdc_o <= 1'b1;
    s = mdio_o;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic xfer(input logic wr, input logic [4:0] ra, input logic [15:0] wv,
                      output logic [15:0] rv);
    logic [63:0] f;
    logic s;
    f = {32'hFFFFFFFF, 2'b01, wr ? 2'b01 : 2'b10, 5'h01, ra, 2'b10, wv};
    oe_ff <= 1'b1;
    for (int i = 63; i >= 0; i--) begin
      if (!wr && i == 17) oe_ff <= 1'b0;
      bit_t(f[i], s);
      if (i < 16) rv[i] = s;
    end
    oe_ff <= 1'b0;
    d_ff <= 1'b1;
    mdc_o <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
endmodule // pvc_mdio_host

//--- verif/tb_phy_vendor_ctrl_status_irqmask.sv
// self-checking bench for the vendor management bank
// assumes every register access goes through the host model
`timescale 1ns/1ps
`include "pvc_defines.vh"
module tb_phy_vendor_ctrl_status_irqmask;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        sp, pw;
  logic        link = 1'b0, rxp = 1'b0, rxs = 1'b0, rxv = 1'b0, rxa = 1'b0, txa = 1'b0;
  logic [15:0] ev = 16'h0000;
  int          error_cnt = 0, num_checks = 0, ns_cnt = 0, fs_cnt = 0;
  wire mdc, mdio, d_o, d_oe, lo, hi, neg, nsc, slc, slp, fsr, spd, pwr, lrx, ltx, irq_n;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (nsc === 1'b1) ns_cnt <= ns_cnt + 1;
    if (fsr === 1'b1) fs_cnt <= fs_cnt + 1;
  end
  pvc_mdio_host host (.clk_i(clk), .dev_d_i(d_o), .dev_oe_i(d_oe), .mdc_o(mdc), .mdio_o(mdio));
  pvc_vendor_regs #(.LED_LEN(16'h0008)) dut (
    .clk_i(clk), .rst_i(rst), .ce_i(ce), .mdc_i(mdc), .mdio_i(mdio), .mdio_o(d_o),
    .mdio_oe_o(d_oe), .speed_strap_pin_i(sp), .power_strap_pin_i(pw), .link_up_flag_i(link),
    .rx_power_level_i(rxp), .rx_speed_level_i(rxs), .rx_version_nonzero_i(rxv),
    .sw_irq_set_i(ev[15:10]), .rx_mgmt_word_valid_set_i(ev[9]),
    .tx_mgmt_word_ready_set_i(ev[8]), .frame_received_i(ev[3]), .frame_sent_i(ev[2]),
    .remote_cmd_in_i(ev[1]), .remote_cmd_out_i(ev[0]), .rx_act_i(rxa), .tx_act_i(txa),
    .remote_low_speed_cmd_o(lo), .remote_high_speed_cmd_o(hi),
    .node_addr_negotiation_stop_o(neg), .noise_event_clear_o(nsc),
    .slice_adapt_freeze_o(slc), .sleep_request_o(slp), .fsm_reset_o(fsr),
    .speed_high_o(spd), .power_high_o(pwr), .led_rx_o(lrx), .led_tx_o(ltx), .irq_n_o(irq_n));
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // status word from {ledbyp, link, rxpwr, rxspd, rxver}; reserved bits read zero
  function automatic logic [15:0] stat_exp(input logic [4:0] s);
    return {5'h00, s[3], s[4], 2'b00, s[2:0], 4'h0};
  endfunction
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    logic [15:0] x;
    host.xfer(1'b1, a, v, x);
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    host.xfer(1'b0, a, 16'h0000, v);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  initial begin
    logic [15:0] v, x, m;
    logic [31:0] r;
    logic        old;
    int          n0, f0;
    void'($urandom(32'h1d106734));
    r = $urandom;
    sp <= r[0];
    pw <= r[1];
    old = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk({spd, pwr}, {sp, pw}, "strap outs");
    rd(`PVC_ADDR_CTRL, v);
    chk(v, {13'h0000, sp, pw, 1'b1}, "ctrl reset");
    rd(`PVC_ADDR_STAT, v);
    chk(v, 16'h0000, "stat reset");
    rd(`PVC_ADDR_MASK, v);
    chk(v, 16'h0000, "mask reset");
    rd(5'h15, v);
    chk(v, 16'h0000, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      v = (i == 0) ? 16'hFFF3 : (i == 1) ? 16'h03E3 : ((r[15:0] & 16'hFFF7) | 16'h0001);
      n0 = ns_cnt;
      f0 = fs_cnt;
      wr(`PVC_ADDR_CTRL, v);
      chk({lo, hi, neg, slc, slp, spd, pwr}, {v[9:7], v[5:4], v[2:1]}, "ctrl outs");
      chk(16'(ns_cnt - n0), {15'h0000, v[6]}, "noise clear");
      chk(16'(fs_cnt - f0), {15'h0000, old & ~v[4]}, "state reset");
      rd(`PVC_ADDR_CTRL, x);
      chk(x, v & `PVC_CTRL_WMASK, "ctrl readback");
      old = v[4];
    end
    $display("test control done");
    for (int i = 0; i < 6; i++) begin
      r = $urandom;
      r[4] = i[0];
      @(posedge clk);
      {link, rxp, rxs, rxv} <= r[3:0];
      wr(`PVC_ADDR_STAT, {6'h00, r[4], 9'h000});
      rd(`PVC_ADDR_STAT, v);
      chk(v, stat_exp(r[4:0]), "status");
      rxa <= 1'b1;
      txa <= 1'b1;
      @(posedge clk);
      rxa <= 1'b0;
      txa <= 1'b0;
      repeat (5) @(posedge clk);
      chk({lrx, ltx}, {2{~r[4]}}, "led stretch");
    end
    $display("test status done");
    for (int b = 0; b < 16; b++) if (b < 4 || b > 7) begin
      m = 16'h0001 << b;
      wr(`PVC_ADDR_INTERRUPT_STATUS_REG, 16'hFFFF);
      wr(`PVC_ADDR_MASK, m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 16'h0000;
      repeat (4) @(posedge clk);
      chk(irq_n, 1'b1, "masked source");
      rd(`PVC_ADDR_INTERRUPT_STATUS_REG, v);
      chk(v, m, "flag recorded");
      wr(`PVC_ADDR_MASK, ~m & 16'hFF0F);
      chk(irq_n, 1'b0, "unmasked source");
      wr(`PVC_ADDR_INTERRUPT_STATUS_REG, m);
      chk(irq_n, 1'b1, "flag cleared");
    end
    $display("test mask done");
    // an event while the enable is low must leave no trace
    @(posedge clk);
    ce <= 1'b0;
    ev <= 16'h8000;
    @(posedge clk);
    ev <= 16'h0000;
    repeat (4) @(posedge clk);
    chk(irq_n, 1'b1, "frozen irq");
    ce <= 1'b1;
    rd(`PVC_ADDR_INTERRUPT_STATUS_REG, v);
    chk(v, 16'h0000, "frozen flag");
    @(posedge clk);
    ev <= 16'h8000;
    @(posedge clk);
    ev <= 16'h0000;
    repeat (4) @(posedge clk);
    chk(irq_n, 1'b0, "enabled irq");
    $display("test enable done");
    // second reset with the other strap levels
    sp <= ~sp;
    pw <= ~pw;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk({irq_n, spd, pwr}, {1'b1, sp, pw}, "second reset");
    rd(`PVC_ADDR_CTRL, v);
    chk(v, {13'h0000, sp, pw, 1'b1}, "ctrl after reset");
    rd(`PVC_ADDR_INTERRUPT_STATUS_REG, v);
    chk(v, 16'h0000, "flags after reset");
    $display("test second reset done");
    conclude();
  end
endmodule // tb_phy_vendor_ctrl_status_irqmask
